//--- src/psc_pkg.sv
// package: shared constants for the phase shifter control port
`default_nettype none
package psc_pkg;
   localparam int WORD_BITS = 6;
   localparam int PHASE_BITS = 4;
   localparam int CLK_SYS_NS = 20;
   localparam int SCK_MIN_NS = 100;
   localparam int LES_MIN_NS = 630;
   localparam int SCK_HALF_CYC = (SCK_MIN_NS / 2 + CLK_SYS_NS - 1) / CLK_SYS_NS;
   localparam int LES_MIN_CYC = (LES_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
   localparam logic [3:0] PHASE_RESET = 4'h0;
   localparam logic [5:0] WORD_RESET = 6'h00;
   // bit positions of the six-bit word, msb first on the wire
   localparam int POS_180 = 5;
   localparam int POS_90 = 4;
   localparam int POS_45 = 3;
   localparam int POS_22P5 = 2;
   localparam int POS_SPARE_B = 1;
   localparam int POS_SPARE_A = 0;
endpackage : psc_pkg
`default_nettype wire

//--- src/psc_if.sv
// interface: pins between controller and phase shifter control port
`default_nettype none
interface psc_if;
   logic serial_select;
   logic load_strobe;
   logic serial_clk;
   logic serial_data_in;
   logic phase_bit_180;
   logic phase_bit_90;
   logic phase_bit_45;
   logic serial_data_out;
   // pin22/23/24 carry load_strobe/serial_clk/serial_data_in or 22p5/spare_b/spare_a
   modport device (
      input serial_select, load_strobe, serial_clk, serial_data_in,
      input phase_bit_180, phase_bit_90, phase_bit_45,
      output serial_data_out
   );
   modport ctrl (
      output serial_select, load_strobe, serial_clk, serial_data_in,
      output phase_bit_180, phase_bit_90, phase_bit_45,
      input serial_data_out
   );
endinterface : psc_if
`default_nettype wire

//--- src/psc_device.sv
// device end: serial/parallel phase state control with shift-out echo
`default_nettype none
module psc_device (
   input wire logic clk_sys,
   input wire logic nrst,
   psc_if.device pins,
   output logic [3:0] phase_state
);
   // two-flop synchronisers for all pins
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic [7:0] next_sync1;
   logic [7:0] next_sync2;
   logic sel_s, le_s, sck_s, sdi_s, p180_s, p90_s, p45_s;
   logic sck_d, le_d;
   logic next_sck_d, next_le_d;
   logic [5:0] shift_reg;
   logic [5:0] next_shift_reg;
   logic [3:0] next_phase_state;
   logic sdo;
   logic next_sdo;
   logic sck_rise, le_rise;

   always_comb begin
      next_sync1 = {pins.serial_select, pins.load_strobe, pins.serial_clk,
                    pins.serial_data_in, pins.phase_bit_180, pins.phase_bit_90,
                    pins.phase_bit_45, 1'b0};
      next_sync2 = sync1;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end

   assign {sel_s, le_s, sck_s, sdi_s, p180_s, p90_s, p45_s} = sync2[7:1];
   assign sck_rise = sck_s && !sck_d && sel_s && !le_s;
   assign le_rise = le_s && !le_d && sel_s;

   // shift chain, phase update and echo output
   always_comb begin
      next_sck_d = sck_s;
      next_le_d = le_s;
      next_shift_reg = shift_reg;
      next_sdo = sdo;
      next_phase_state = phase_state;
      if (sck_rise) begin
         next_shift_reg = {shift_reg[4:0], sdi_s};
         next_sdo = shift_reg[5];
      end
      if (!sel_s) begin
         // pin22 is the 22.5 degree bit here
         next_phase_state = {p180_s, p90_s, p45_s, le_s};
      end else if (le_rise) begin
         next_phase_state = {shift_reg[psc_pkg::POS_180], shift_reg[psc_pkg::POS_90],
                             shift_reg[psc_pkg::POS_45],
                             shift_reg[psc_pkg::POS_22P5]};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sck_d <= 1'b0;
         le_d <= 1'b0;
         shift_reg <= psc_pkg::WORD_RESET;
         sdo <= 1'b0;
         phase_state <= psc_pkg::PHASE_RESET;
      end else begin
         sck_d <= next_sck_d;
         le_d <= next_le_d;
         shift_reg <= next_shift_reg;
         sdo <= next_sdo;
         phase_state <= next_phase_state;
      end
   end

   assign pins.serial_data_out = sdo;
endmodule : psc_device
`default_nettype wire

//--- src/psc_ctrl.sv
// controller end: drives a six-bit serial word or parallel bits
`default_nettype none
module psc_ctrl (
   input wire logic clk_sys,
   input wire logic nrst,
   psc_if.ctrl pins,
   input wire logic req,
   input wire logic req_serial,
   input wire logic [3:0] req_phase,
   input wire logic [1:0] req_spare,
   output logic busy,
   output logic [5:0] echo_word
);
   typedef enum logic [2:0] {PSC_IDLE, PSC_LOW, PSC_HIGH, PSC_LOAD, PSC_GAP} psc_state_t;
   psc_state_t state, next_state;
   logic [5:0] word, next_word;
   logic [5:0] echo, next_echo;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [5:0] tmr, next_tmr;
   logic sel, le, sck, sdi, p180, p90, p45;
   logic next_sel, next_le, next_sck, next_sdi, next_p180, next_p90, next_p45;
   logic next_busy;
   logic sdo_m, sdo_s, next_sdo_m;

   // sequence: low half, high half per bit, then strobe and gap
   always_comb begin
      next_state = state;
      next_word = word;
      next_echo = echo;
      next_bit_cnt = bit_cnt;
      next_tmr = tmr;
      next_sel = sel;
      next_le = le;
      next_sck = sck;
      next_sdi = sdi;
      next_p180 = p180;
      next_p90 = p90;
      next_p45 = p45;
      next_busy = busy;
      next_sdo_m = pins.serial_data_out;
      case (state)
         PSC_IDLE: begin
            if (req) begin
               next_busy = 1'b1;
               next_sel = req_serial;
               if (req_serial) begin
                  next_word = {req_phase, req_spare};
                  next_bit_cnt = 3'(psc_pkg::WORD_BITS);
                  next_le = 1'b0;
                  next_sck = 1'b0;
                  next_tmr = 6'(psc_pkg::SCK_HALF_CYC);
                  next_state = PSC_LOW;
               end else begin
                  {next_p180, next_p90, next_p45, next_le} = req_phase;
                  next_sck = req_spare[1];
                  next_sdi = req_spare[0];
                  next_tmr = 6'(psc_pkg::LES_MIN_CYC);
                  next_state = PSC_GAP;
               end
            end
         end
         PSC_LOW: begin
            next_sdi = word[5];
            next_tmr = tmr - 6'h01;
            if (tmr == 6'h01) begin
               next_sck = 1'b1;
               next_tmr = 6'(psc_pkg::SCK_HALF_CYC);
               next_state = PSC_HIGH;
            end
         end
         PSC_HIGH: begin
            next_tmr = tmr - 6'h01;
            if (tmr == 6'h01) begin
               next_sck = 1'b0;
               next_echo = {echo[4:0], sdo_s};
               next_word = {word[4:0], 1'b0};
               next_bit_cnt = bit_cnt - 3'h1;
               next_tmr = 6'(psc_pkg::SCK_HALF_CYC);
               next_state = (bit_cnt == 3'h1) ? PSC_LOAD : PSC_LOW;
            end
         end
         PSC_LOAD: begin
            next_tmr = tmr - 6'h01;
            if (tmr == 6'h01) begin
               next_le = 1'b1;
               next_tmr = 6'(psc_pkg::LES_MIN_CYC);
               next_state = PSC_GAP;
            end
         end
         PSC_GAP: begin
            next_tmr = tmr - 6'h01;
            if (sel && tmr == 6'(psc_pkg::LES_MIN_CYC - psc_pkg::SCK_HALF_CYC)) begin
               next_le = 1'b0;
            end
            if (tmr == 6'h01) begin
               next_busy = 1'b0;
               next_state = PSC_IDLE;
            end
         end
         default: next_state = PSC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state <= PSC_IDLE;
         word <= psc_pkg::WORD_RESET;
         echo <= psc_pkg::WORD_RESET;
         bit_cnt <= 3'h0;
         tmr <= 6'h00;
         sel <= 1'b1;
         le <= 1'b0;
         sck <= 1'b0;
         sdi <= 1'b0;
         p180 <= 1'b0;
         p90 <= 1'b0;
         p45 <= 1'b0;
         busy <= 1'b0;
         sdo_m <= 1'b0;
         sdo_s <= 1'b0;
      end else begin
         state <= next_state;
         word <= next_word;
         echo <= next_echo;
         bit_cnt <= next_bit_cnt;
         tmr <= next_tmr;
         sel <= next_sel;
         le <= next_le;
         sck <= next_sck;
         sdi <= next_sdi;
         p180 <= next_p180;
         p90 <= next_p90;
         p45 <= next_p45;
         busy <= next_busy;
         sdo_m <= next_sdo_m;
         sdo_s <= sdo_m;
      end
   end

   assign echo_word = echo;
   assign pins.serial_select = sel;
   assign pins.load_strobe = le;
   assign pins.serial_clk = sck;
   assign pins.serial_data_in = sdi;
   assign pins.phase_bit_180 = p180;
   assign pins.phase_bit_90 = p90;
   assign pins.phase_bit_45 = p45;
endmodule : psc_ctrl
`default_nettype wire

//--- tb/psc_monitor.sv
// checker: wire-level timing and ordering between the two ends
`default_nettype none
module psc_monitor (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic serial_select,
   input wire logic load_strobe,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic serial_data_out
);
   logic sck_q, stb_q;
   logic [3:0] rises, next_rises;
   logic [5:0] gap, next_gap;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // clock rises since the last load, and cycles since the last load
   always_comb begin
      next_rises = rises + {3'h0, serial_clk & ~sck_q};
      if (!serial_select || (load_strobe & ~stb_q)) next_rises = 4'h0;
      next_gap = (gap == 6'h3F) ? gap : gap + 6'h01;
      if (serial_select & load_strobe & ~stb_q) next_gap = 6'h00;
   end
   // registers the counters and previous pin levels
   always_ff @(posedge clk_sys) begin
      sck_q <= nrst & serial_clk;
      stb_q <= nrst & load_strobe;
      rises <= nrst ? next_rises : 4'h0;
      gap <= nrst ? next_gap : 6'h3F;
   end
   a_load_gap: assert property ($rose(load_strobe) && serial_select |-> gap >= 6'h1F)
      else $error("load pulses too close");
   a_six_before_load: assert property ($rose(load_strobe) && serial_select |-> rises == 4'h6)
      else $error("load without six clock rises");
   a_sck_high_min: assert property ($rose(serial_clk) && serial_select |-> serial_clk[*3])
      else $error("serial clock high too short");
   a_sck_low_min: assert property ($fell(serial_clk) && serial_select |-> !serial_clk[*3])
      else $error("serial clock low too short");
   a_no_clk_loading: assert property (serial_select && load_strobe |-> !$rose(serial_clk))
      else $error("clock rise while load high");
   a_data_steady: assert property (serial_select && $past(serial_select) && serial_clk
      && $past(serial_clk) |-> $stable(serial_data_in))
      else $error("data moved while clock high");
   a_out_still_load: assert property ((serial_select && load_strobe)[*3] |->
      $stable(serial_data_out))
      else $error("echo moved while load high");
   a_out_idle_par: assert property ((!serial_select)[*4] |-> $stable(serial_data_out))
      else $error("echo moved in parallel mode");
   c_load: cover property ($rose(load_strobe) && serial_select);
   c_parallel: cover property ($fell(serial_select));
   c_echo: cover property ($changed(serial_data_out));
endmodule : psc_monitor
`default_nettype wire

//--- tb/tb.sv
// testbench: controller and device joined, plus a hand-driven device
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic req = 1'b0;
   logic req_serial = 1'b0;
   logic busy, sck_q;
   logic [3:0] req_phase = 4'h0;
   logic [1:0] req_spare = 2'h0;
   logic [3:0] phase_state, phase_two;
   logic [5:0] echo_word;
   // last two words sent on the joined link, for the echo expectation
   logic [5:0] word_prev1 = 6'h00;
   logic [5:0] word_prev2 = 6'h00;
   logic [3:0] rises = 4'h0;
   logic [7:0] hist = 8'h00;
   int failures = 0;
   int checks_done = 0;
   psc_if bus();
   psc_if bus2();
   psc_ctrl psc_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .pins(bus.ctrl), .req(req),
      .req_serial(req_serial), .req_phase(req_phase), .req_spare(req_spare), .busy(busy),
      .echo_word(echo_word));
   psc_device psc_device_inst (.clk_sys(clk_sys), .nrst(nrst), .pins(bus.device),
      .phase_state(phase_state));
   psc_device psc_device_fault_inst (.clk_sys(clk_sys), .nrst(nrst), .pins(bus2.device),
      .phase_state(phase_two));
   psc_monitor psc_monitor_inst (.clk_sys(clk_sys), .nrst(nrst),
      .serial_select(bus.serial_select), .load_strobe(bus.load_strobe),
      .serial_clk(bus.serial_clk), .serial_data_in(bus.serial_data_in),
      .serial_data_out(bus.serial_data_out));
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   // echo chain: data out against the bit taken seven rises back
   always @(negedge clk_sys) begin
      sck_q <= bus.serial_clk;
      if (!nrst || !bus.serial_select) begin
         rises <= 4'h0;
      end else if (bus.serial_clk && !sck_q && !bus.load_strobe) begin
         if (rises == 4'h7) check("echo", {3'h0, bus.serial_data_out}, {3'h0, hist[6]});
         else rises <= rises + 4'h1;
         hist <= {hist[6:0], bus.serial_data_in};
      end
   end
   // one controller request, waits for it to finish
   task automatic run_req(input logic ser, input logic [3:0] ph, input logic [1:0] sp);
      int k;
      k = 0;
      req = 1'b1;
      req_serial = ser;
      req_phase = ph;
      req_spare = sp;
      @(negedge clk_sys);
      req = 1'b0;
      while (busy !== 1'b0 && k < 300) begin
         @(negedge clk_sys);
         k++;
      end
      // a request that never finishes counts as a mismatch
      if (k >= 300) begin
         failures++;
         $display("[FAIL] busy expected 0 seen %b", busy);
      end
   endtask : run_req
   // serial words back to back, every phase, spare bits varied
   task automatic t_serial;
      logic [5:0] w;
      logic [5:0] e;
      for (int i = 0; i < 16; i++) begin
         w = {4'hF - i[3:0], i[1:0]};
         // each echoed bit is the one sent seven accepted rises before it
         e = {word_prev2[0], word_prev1[5:1]};
         run_req(1'b1, 4'hF - i[3:0], i[1:0]);
         check("serial phase", phase_state, 4'hF - i[3:0]);
         check("echo word high", echo_word[5:2], e[5:2]);
         check("echo word low", {2'h0, echo_word[1:0]}, {2'h0, e[1:0]});
         word_prev2 = word_prev1;
         word_prev1 = w;
      end
   endtask : t_serial
   // parallel settings on the shared pins
   task automatic t_parallel;
      for (int i = 0; i < 16; i++) begin
         run_req(1'b0, i[3:0], ~i[1:0]);
         check("parallel phase", phase_state, i[3:0]);
      end
   endtask : t_parallel
   // hand-driven frames on the second device, four system cycles per serial clock half
   task automatic put_word(input logic [5:0] w);
      for (int i = 5; i >= 0; i--) begin
         bus2.serial_data_in = w[i];
         bus2.serial_clk = 1'b0;
         repeat (4) @(negedge clk_sys);
         bus2.serial_clk = 1'b1;
         repeat (4) @(negedge clk_sys);
      end
      bus2.serial_clk = 1'b0;
      bus2.serial_data_in = ~w[0];
      repeat (4) @(negedge clk_sys);
   endtask : put_word
   task automatic pulse_load;
      bus2.load_strobe = 1'b1;
      repeat (4) @(negedge clk_sys);
      bus2.load_strobe = 1'b0;
      repeat (32) @(negedge clk_sys);
   endtask : pulse_load
   // clocks while loading or disabled must not touch the shifted word
   task automatic t_fault;
      put_word(6'h2D);
      check("held before load", phase_two, 4'h0);
      pulse_load();
      check("serial load", phase_two, 4'hB);
      bus2.load_strobe = 1'b1;
      put_word(6'h12);
      bus2.load_strobe = 1'b0;
      repeat (32) @(negedge clk_sys);
      pulse_load();
      check("masked clocks", phase_two, 4'hB);
      bus2.serial_select = 1'b0;
      {bus2.phase_bit_180, bus2.phase_bit_90, bus2.phase_bit_45, bus2.load_strobe} = 4'h7;
      put_word(6'h00);
      check("direct pins", phase_two, 4'h7);
      bus2.load_strobe = 1'b0;
      repeat (8) @(negedge clk_sys);
      bus2.serial_select = 1'b1;
      repeat (8) @(negedge clk_sys);
      check("held on entry", phase_two, 4'h6);
      pulse_load();
      check("disabled clocks", phase_two, 4'hB);
   endtask : t_fault
   // system clock
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // watchdog
   initial begin
      #400000;
      failures++;
      report_and_stop();
   end
   // main sequence
   initial begin
      {bus2.serial_select, bus2.load_strobe, bus2.serial_clk, bus2.serial_data_in} = 4'h8;
      {bus2.phase_bit_180, bus2.phase_bit_90, bus2.phase_bit_45} = 3'h0;
      repeat (12) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_serial();
      t_parallel();
      t_serial();
      t_fault();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
